// [design/bdm_data_mem.sv]
/*
 * banked data memory: bank pointer, address forming, gpr array,
 * usb dual-port window on banks 4..7, sfr region pass-out.
 * assumes core requests are one-cycle strobes synchronous to clk_sys.
 * IMPL_BANKS must be a power of two covering banks 4..7, below 16.
 */
// Notes on behaviour
// RULE_01: banks 4-7 are dual-port ram; ordinary gprs while usb is off.
// RULE_02: with usb on, core and serial engine both reach banks 4-7.
// RULE_03: software should keep bank 4 for descriptors while usb is on.
// RULE_04: sixteen 256-byte banks; full 12-bit or bank plus offset.
// RULE_05: bank pointer gives high four bits, operand the low eight.
// RULE_06: only low four bank pointer bits exist; upper read zero.
// RULE_07: load bank literal instruction writes the bank pointer.
// RULE_08: unimplemented bank writes ignored, reads return zero.
// RULE_09: status flags update as usual on unimplemented accesses.
// RULE_10: full address move uses two 12-bit addresses, no bank pointer.
// RULE_11: access bank: 00-5f to bank 0, 60-ff to top of bank 15.
// RULE_12: access select one uses bank pointer plus offset.
// RULE_13: access select zero uses access map, ignores bank pointer.
// RULE_14: access bank reach takes one cycle, no pointer update first.
// RULE_15: gpr space starts at 000h and grows upward.
// RULE_16: gpr contents untouched by any reset.
// RULE_17: sfrs occupy f53h-fffh; unused sfr reads return zero.
// RULE_18: serial engine port into banks 4-7 only while usb enabled.
`include "bdm_defs.svh"

module bdm_data_mem
	import bdm_pkg::*;
#(
	parameter int IMPL_BANKS = 8
)
(
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              usbEnable,
	input  wire logic              coreRead,
	input  wire logic              coreWrite,
	input  wire logic              accessSelect,
	input  wire logic              fullMove,
	input  wire bdm_pkg::bdm_byte_t opOffset,
	input  wire bdm_pkg::bdm_addr_t moveSrcAddr,
	input  wire bdm_pkg::bdm_addr_t moveDstAddr,
	input  wire bdm_pkg::bdm_byte_t coreWdata,
	input  wire logic              loadBank,
	input  wire bdm_pkg::bdm_byte_t bankLiteral,
	input  wire logic              bankPtrWrite,
	input  wire bdm_pkg::bdm_byte_t bankPtrWdata,
	input  wire bdm_pkg::bdm_byte_t sfrRdata,
	input  wire logic              usbRead,
	input  wire logic              usbWrite,
	input  wire logic [9:0]        usbAddr,
	input  wire bdm_pkg::bdm_byte_t usbWdata,
	output bdm_pkg::bdm_byte_t     coreRdata,
	output logic                   coreRvalid,
	output bdm_pkg::bdm_byte_t     bankPtrRead,
	output bdm_pkg::bdm_addr_t     sfrAddr,
	output logic                   sfrRead,
	output logic                   sfrWrite,
	output bdm_pkg::bdm_byte_t     sfrWdata,
	output bdm_pkg::bdm_byte_t     usbRdata,
	output logic                   usbRvalid,
	output logic                   moveDone
);
	import bdm_pkg::*;

	// bank index below assumes a power-of-two bank count
	localparam int BANK_BYTES = `BDM_BANK_BYTES;
	localparam int GPR_BYTES  = IMPL_BANKS * BANK_BYTES;
	localparam int BANK_SEL_W = $clog2(IMPL_BANKS);

	bdm_bank_t  bankPtr_r;
	bdm_bank_t  bankPtr_nxt;
	bdm_state_t moveState_nxt;
	bdm_byte_t  coreBankRd [IMPL_BANKS];
	bdm_byte_t  usbBankRd  [IMPL_BANKS];
	logic       coreBankWe [IMPL_BANKS];
	logic       usbBankWe  [IMPL_BANKS];
	bdm_byte_t  coreRdByte;
	bdm_byte_t  usbRdByte;
	bdm_addr_t  usbFullAddr;
	bdm_mode_t  mode;
	bdm_addr_t  coreAddr;
	bdm_addr_t  writeAddr;
	bdm_state_t moveState_r;
	bdm_byte_t  moveData_r;
	logic       moveWrite;
	bdm_byte_t  writeData;
	logic       isSfr;
	logic       isImpl;
	logic       doWrite;
	logic       usbGrant;
	logic       wrIsSfr;
	logic       wrIsImpl;

	// the move reads its source first, then writes its destination
	always_comb
	begin
		if (fullMove || moveState_r == BDM_ST_WRITE)
			mode = BDM_MODE_FULL;
		else if (accessSelect)
			mode = BDM_MODE_BANKED; // RULE_12
		else
			mode = BDM_MODE_ACCESS; // RULE_14
	end

	// one former serves the core operand and the move source alike
	bdm_addr_form uForm
	(
		.mode     (mode),
		.bankPtr  (bankPtr_r),
		.offset   (opOffset),
		.fullAddr (moveSrcAddr),
		.addr     (coreAddr)
	);

	assign moveWrite = (moveState_r == BDM_ST_WRITE);
	assign writeAddr = moveWrite ? moveDstAddr : coreAddr;
	assign writeData = moveWrite ? moveData_r : coreWdata;
	assign doWrite   = moveWrite || (coreWrite && !fullMove);
	assign isSfr     = coreAddr >= `BDM_SFR_BASE; // RULE_17
	assign isImpl    = coreAddr < `BDM_ADDR_W'(GPR_BYTES); // RULE_15
	assign wrIsSfr   = writeAddr >= `BDM_SFR_BASE;
	assign wrIsImpl  = writeAddr < `BDM_ADDR_W'(GPR_BYTES);
	assign usbGrant  = usbEnable; // RULE_18
	// engine offsets are relative to the base of bank 4
	assign usbFullAddr = `BDM_USB_BASE | bdm_addr_t'(usbAddr);

	// bank pointer: only four bits stored; literal load outranks sfr write
	always_comb
	begin
		bankPtr_nxt = bankPtr_r;
		if (loadBank)
			bankPtr_nxt = bankLiteral[`BDM_BANK_W-1:0]; // RULE_07
		else if (bankPtrWrite)
			bankPtr_nxt = bankPtrWdata[`BDM_BANK_W-1:0]; // RULE_06
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			bankPtr_r <= `BDM_BSR_RESET;
		else
			bankPtr_r <= bankPtr_nxt;
	end

	always_ff @(posedge clk_sys)
	begin
		bankPtrRead <= {`BDM_BSR_PAD, bankPtr_r}; // RULE_06
	end

	// full address move: source read now, destination write next cycle
	always_comb
	begin
		moveState_nxt = moveState_r;
		case (moveState_r)
			BDM_ST_IDLE:
				if (fullMove)
					moveState_nxt = BDM_ST_WRITE; // RULE_10
			BDM_ST_WRITE:
				moveState_nxt = BDM_ST_IDLE;
			default:
				moveState_nxt = BDM_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			moveState_r <= BDM_ST_IDLE;
		else
			moveState_r <= moveState_nxt;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			moveDone <= 1'b0;
		else
			moveDone <= moveWrite;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			moveData_r <= `BDM_ZERO_BYTE;
		else if (fullMove && moveState_r == BDM_ST_IDLE)
			moveData_r <= coreRdByte; // RULE_10
	end

	// one slice per implemented bank; contents see no reset at all
	for (genvar bk = 0; bk < IMPL_BANKS; bk++)
	begin : g_bank
		bdm_byte_t bankMem [BANK_BYTES];
		logic      usbLane;
		logic      coreHere;
		logic      usbHere;

		// only banks 4..7 carry the serial engine's second port
		assign usbLane  = bdm_bank_t'(bk) >= `BDM_BANK_USB_LO &&
			bdm_bank_t'(bk) <= `BDM_BANK_USB_HI; // RULE_01
		assign coreHere = writeAddr[`BDM_ADDR_W-1:`BDM_OFS_W] ==
			bdm_bank_t'(bk);
		assign usbHere  = usbFullAddr[`BDM_ADDR_W-1:`BDM_OFS_W] ==
			bdm_bank_t'(bk);
		assign coreBankWe[bk] = doWrite && wrIsImpl && !wrIsSfr &&
			coreHere; // RULE_08
		// same-byte clash: the core write wins, the engine's is dropped
		assign usbBankWe[bk]  = usbLane && usbGrant && usbWrite && usbHere &&
			!(coreBankWe[bk] && writeAddr == usbFullAddr); // RULE_02

		// core lane and engine lane may hit different bytes in one cycle
		always_ff @(posedge clk_sys)
		begin
			if (coreBankWe[bk])
				bankMem[writeAddr[`BDM_OFS_W-1:0]] <= writeData; // RULE_16
			if (usbBankWe[bk])
				bankMem[usbFullAddr[`BDM_OFS_W-1:0]] <= usbWdata; // RULE_02
		end

		assign coreBankRd[bk] = bankMem[coreAddr[`BDM_OFS_W-1:0]];
		assign usbBankRd[bk]  = bankMem[usbFullAddr[`BDM_OFS_W-1:0]];
	end

	// reads of unimplemented banks come back as zero
	always_comb
	begin
		coreRdByte = `BDM_ZERO_BYTE; // RULE_08
		if (isSfr)
			coreRdByte = sfrRdata; // RULE_17
		else if (isImpl)
			coreRdByte = coreBankRd[coreAddr[`BDM_OFS_W +: BANK_SEL_W]];
	end

	assign usbRdByte = usbBankRd[usbFullAddr[`BDM_OFS_W +: BANK_SEL_W]];

	// core read path, one cycle after the strobe
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			coreRdata <= `BDM_ZERO_BYTE;
		else if (coreRead && !fullMove)
			coreRdata <= coreRdByte; // RULE_01
	end

	// valid still pulses on unimplemented reads so flags update
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			coreRvalid <= 1'b0;
		else
			coreRvalid <= coreRead && !fullMove; // RULE_09
	end

	// sfr pass-out strobes, registered
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			sfrRead  <= 1'b0;
			sfrWrite <= 1'b0;
		end
		else
		begin
			sfrRead  <= coreRead && isSfr; // RULE_17
			sfrWrite <= doWrite && wrIsSfr; // RULE_17
		end
	end

	// address and data follow every cycle; only the strobes qualify them
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			sfrAddr  <= `BDM_SFR_BASE;
			sfrWdata <= `BDM_ZERO_BYTE;
		end
		else
		begin
			sfrAddr  <= doWrite ? writeAddr : coreAddr;
			sfrWdata <= writeData;
		end
	end

	// usb serial engine port, banks 4..7 only
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			usbRvalid <= 1'b0;
		else
			usbRvalid <= usbGrant && usbRead; // RULE_18
	end

	// data is zero outside an answer so a disabled port leaks nothing
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			usbRdata <= `BDM_ZERO_BYTE;
		else if (usbGrant && usbRead)
			usbRdata <= usbRdByte; // RULE_02
		else
			usbRdata <= `BDM_ZERO_BYTE;
	end
endmodule : bdm_data_mem

// [design/bdm_defs.svh]
/*
 * constants for the banked data memory address logic.
 * assumes inclusion by bdm_pkg and the design modules only.
 */
`ifndef BDM_DEFS_SVH
`define BDM_DEFS_SVH

`define BDM_ADDR_W        12
`define BDM_BANK_W        4
`define BDM_OFS_W         8
`define BDM_BANK_BYTES    256
`define BDM_USB_BASE      12'h400
`define BDM_BANK_USB_LO   4'h4
`define BDM_BANK_USB_HI   4'h7
`define BDM_BANK_TOP      4'hf
`define BDM_BANK_ZERO     4'h0
`define BDM_ACC_SPLIT     8'h60
`define BDM_SFR_BASE      12'hf53
`define BDM_GPR_TOP       12'hf52
`define BDM_BSR_RESET     4'h0
`define BDM_BSR_PAD       4'h0
`define BDM_ZERO_BYTE     8'h00

`endif

// [design/bdm_pkg.sv]
/*
 * types shared by the banked data memory address logic.
 * assumes bdm_defs.svh sits beside it.
 */
`include "bdm_defs.svh"

package bdm_pkg;
	typedef logic [`BDM_ADDR_W-1:0] bdm_addr_t;
	typedef logic [`BDM_BANK_W-1:0] bdm_bank_t;
	typedef logic [`BDM_OFS_W-1:0]  bdm_byte_t;
	typedef enum logic [1:0]
	{
		BDM_MODE_BANKED,
		BDM_MODE_ACCESS,
		BDM_MODE_FULL
	} bdm_mode_t;
	typedef enum logic [1:0]
	{
		BDM_ST_IDLE,
		BDM_ST_READ,
		BDM_ST_WRITE
	} bdm_state_t;
endpackage : bdm_pkg

// [design/bdm_addr_form.sv]
/*
 * combinational address former: banked, access bank or full 12-bit.
 * assumes operands are stable in the cycle they are used.
 */
`include "bdm_defs.svh"

module bdm_addr_form
	import bdm_pkg::*;
(
	input  wire bdm_pkg::bdm_mode_t mode,
	input  wire bdm_pkg::bdm_bank_t bankPtr,
	input  wire bdm_pkg::bdm_byte_t offset,
	input  wire bdm_pkg::bdm_addr_t fullAddr,
	output bdm_pkg::bdm_addr_t      addr
);
	import bdm_pkg::*;

	always_comb
	begin
		case (mode) // RULE_04
			BDM_MODE_BANKED:
				addr = {bankPtr, offset}; // RULE_05
			BDM_MODE_ACCESS:
				if (offset < `BDM_ACC_SPLIT) // RULE_11
					addr = {`BDM_BANK_ZERO, offset};
				else
					addr = {`BDM_BANK_TOP, offset}; // RULE_13
			BDM_MODE_FULL:
				addr = fullAddr; // RULE_10
			default:
				addr = fullAddr;
		endcase
	end
endmodule : bdm_addr_form

// [tb/bdm_sfr_model.sv]
/* far-side sfr block model.
   assumes sfrAddr comes from bdm_data_mem. */
module bdm_sfr_model
	import bdm_pkg::*;
(
	input  wire bdm_pkg::bdm_addr_t sfrAddr,
	output bdm_pkg::bdm_byte_t      sfrRdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// nothing implemented, so every address is an unused one
	assign sfrRdata = 8'h00;
endmodule : bdm_sfr_model

// [tb/bdm_data_mem_checker.sv]
/* port assertions for bdm_data_mem.
   assumes the bind below reaches every instance. */
module bdm_checker
	import bdm_pkg::*;
(
	input wire logic               clk_sys,
	input wire logic               rst_n,
	input wire logic               usbEnable,
	input wire logic               coreRead,
	input wire logic               coreWrite,
	input wire logic               accessSelect,
	input wire logic               fullMove,
	input wire bdm_pkg::bdm_byte_t opOffset,
	input wire bdm_pkg::bdm_byte_t coreWdata,
	input wire logic               loadBank,
	input wire bdm_pkg::bdm_byte_t bankLiteral,
	input wire logic               usbRead,
	input wire logic               coreRvalid,
	input wire bdm_pkg::bdm_byte_t bankPtrRead,
	input wire bdm_pkg::bdm_addr_t sfrAddr,
	input wire logic               sfrRead,
	input wire logic               sfrWrite,
	input wire bdm_pkg::bdm_byte_t sfrWdata,
	input wire logic               usbRvalid,
	input wire logic               moveDone
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence s_acc_hi;
		!fullMove && !accessSelect && opOffset >= 8'h60;
	endsequence
	sequence s_move_end;
		##1 moveDone;
	endsequence
	a_read_valid: assert property (coreRead && !fullMove |=> coreRvalid)
		else $error("core read gave no valid");
	a_bank_upper: assert property (bankPtrRead[7:4] == 4'h0)
		else $error("bank pointer upper bits set");
	a_load_bank: assert property (loadBank |=> ##1
		bankPtrRead == ($past(bankLiteral, 2) & 8'h0f))
		else $error("bank literal not loaded");
	a_access_rd: assert property (coreRead ##0 s_acc_hi |=>
		sfrRead && sfrAddr == {4'hf, $past(opOffset)})
		else $error("access read wrong sfr address");
	a_access_wr: assert property (coreWrite ##0 s_acc_hi |=>
		sfrWrite && sfrWdata == $past(coreWdata))
		else $error("access write not forwarded");
	a_usb_read: assert property (usbEnable && usbRead |=> usbRvalid)
		else $error("usb read gave no valid");
	a_usb_off: assert property (!usbEnable && usbRead |=> !usbRvalid)
		else $error("usb port answered while disabled");
	a_move_done: assert property (fullMove |=> s_move_end)
		else $error("move did not finish");
endmodule : bdm_checker

bind bdm_data_mem bdm_checker u_bdm_checker (.clk_sys, .rst_n, .usbEnable,
	.coreRead, .coreWrite, .accessSelect, .fullMove, .opOffset, .coreWdata,
	.loadBank, .bankLiteral, .usbRead, .coreRvalid, .bankPtrRead, .sfrAddr,
	.sfrRead, .sfrWrite, .sfrWdata, .usbRvalid, .moveDone);

// [tb/banked_data_memory_addressing_tb.sv]
/* self-checking bench for bdm_data_mem.
   assumes the checker binds itself to the design. */
module banked_data_memory_addressing_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import bdm_pkg::*;
	logic      clk_sys = 1'b0;
	logic      rst_n, usbEnable, coreRead, coreWrite, accessSelect, fullMove;
	logic      loadBank, bankPtrWrite, usbRead, usbWrite;
	logic      coreRvalid, sfrRead, sfrWrite, usbRvalid, moveDone;
	bdm_byte_t opOffset, coreWdata, bankLiteral, bankPtrWdata, usbWdata;
	bdm_byte_t sfrRdata, coreRdata, bankPtrRead, sfrWdata, usbRdata;
	bdm_addr_t moveSrcAddr, moveDstAddr, sfrAddr;
	logic [9:0] usbAddr;
	int        fails, num_checks;

	always #10 clk_sys = ~clk_sys;
	bdm_data_mem u_bdm_data_mem (.clk_sys, .rst_n, .usbEnable, .coreRead,
		.coreWrite, .accessSelect, .fullMove, .opOffset, .moveSrcAddr,
		.moveDstAddr, .coreWdata, .loadBank, .bankLiteral, .bankPtrWrite,
		.bankPtrWdata, .sfrRdata, .usbRead, .usbWrite, .usbAddr, .usbWdata,
		.coreRdata, .coreRvalid, .bankPtrRead, .sfrAddr, .sfrRead, .sfrWrite,
		.sfrWdata, .usbRdata, .usbRvalid, .moveDone);
	bdm_sfr_model u_bdm_sfr_model (.sfrAddr, .sfrRdata);

	task chk(string nm, logic [11:0] e, logic [11:0] s);
		num_checks++;
		if (s !== e)
		begin
			fails++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task conclude;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	task bank(logic viaSfr, bdm_byte_t lit);
		@(negedge clk_sys);
		{bankPtrWrite, loadBank} = {viaSfr, !viaSfr};
		{bankPtrWdata, bankLiteral} = {lit, lit};
		@(negedge clk_sys);
		{bankPtrWrite, loadBank} = 2'b00;
		@(negedge clk_sys);
		chk("bankPtrRead", {4'h0, lit & 8'h0f}, {4'h0, bankPtrRead});
	endtask : bank

	task core(logic wr, logic sel, bdm_byte_t ofs, bdm_byte_t d);
		@(negedge clk_sys);
		{coreWrite, coreRead, accessSelect} = {wr, !wr, sel};
		{opOffset, coreWdata} = {ofs, d};
		@(negedge clk_sys);
		{coreWrite, coreRead} = 2'b00;
	endtask : core

	task rd(logic sel, bdm_byte_t ofs, bdm_byte_t e);
		core(1'b0, sel, ofs, 8'h00);
		chk("coreRvalid", 12'h1, {11'h0, coreRvalid});
		chk("coreRdata", {4'h0, e}, {4'h0, coreRdata});
	endtask : rd

	task usb(logic wr, logic [9:0] a, bdm_byte_t d);
		@(negedge clk_sys);
		{usbWrite, usbRead, usbAddr, usbWdata} = {wr, !wr, a, d};
		@(negedge clk_sys);
		{usbWrite, usbRead} = 2'b00;
	endtask : usb

	task t_banked;
		bank(1'b0, 8'hf2);
		core(1'b1, 1'b1, 8'h34, 8'ha5);
		rd(1'b1, 8'h34, 8'ha5);
		core(1'b1, 1'b0, 8'h10, 8'h3c);
		core(1'b1, 1'b0, 8'h90, 8'h11);
		core(1'b0, 1'b0, 8'h80, 8'h00);
		chk("sfrAddr", 12'hf80, sfrAddr);
		chk("coreRdata", 12'h0, {4'h0, coreRdata});
		bank(1'b0, 8'h00);
		rd(1'b1, 8'h10, 8'h3c);
	endtask : t_banked

	task t_unimpl;
		bank(1'b1, 8'hf9);
		core(1'b1, 1'b1, 8'h05, 8'h77);
		rd(1'b1, 8'h05, 8'h00);
	endtask : t_unimpl

	task t_move;
		@(negedge clk_sys);
		{fullMove, moveSrcAddr, moveDstAddr} = {1'b1, 12'h234, 12'h456};
		@(negedge clk_sys);
		fullMove = 1'b0;
		@(negedge clk_sys);
		chk("moveDone", 12'h1, {11'h0, moveDone});
		bank(1'b0, 8'h04);
		rd(1'b1, 8'h56, 8'ha5);
	endtask : t_move

	task t_usb;
		usbEnable = 1'b1;
		usb(1'b0, 10'h056, 8'h00);
		chk("usbRdata", 12'ha5, {4'h0, usbRdata});
		chk("usbRvalid", 12'h1, {11'h0, usbRvalid});
		usb(1'b1, 10'h3ff, 8'hc3);
		bank(1'b0, 8'h07);
		rd(1'b1, 8'hff, 8'hc3);
		usbEnable = 1'b0;
		usb(1'b0, 10'h056, 8'h00);
		chk("usbRvalid", 12'h0, {11'h0, usbRvalid});
	endtask : t_usb

	initial
	begin
		{rst_n, usbEnable, coreRead, coreWrite, accessSelect, fullMove} = '0;
		{loadBank, bankPtrWrite, usbRead, usbWrite, usbAddr} = '0;
		{opOffset, coreWdata, bankLiteral, bankPtrWdata, usbWdata} = '0;
		{moveSrcAddr, moveDstAddr, fails, num_checks} = '0;
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		t_banked();
		t_unimpl();
		t_move();
		t_usb();
		conclude();
	end
endmodule : banked_data_memory_addressing_tb
